// [design/cmit_top.sv]
// Message interface transfer: two register sets, arbiter, object RAM
`timescale 1ns/1ns
`default_nettype none
module cmit_top (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [cmit_pkg::ADDR_W-1:0] i_addr,
  input wire logic [cmit_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [cmit_pkg::DATA_W-1:0] o_rdata,
  output logic [1:0] o_busy
);
  import cmit_pkg::*;
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  // The whole message RAM lives in flops, indexed by object
  typedef struct packed {
    cmit_obj_t [NOBJ-1:0] ram; // Message objects
    cmit_eng_t st; // Engine state
    logic [1:0] cnt; // Cycles spent on current transfer
    logic who; // Set being served
    logic last; // Set served last, for fairness
    logic [DATA_W-1:0] rdata; // Read data register
  } cmit_top_t;
  cmit_top_t q; // Registered state
  cmit_top_t next_q; // Next value
  // ------------------------------------------------------------
  // Per-set wires
  // ------------------------------------------------------------
  logic [1:0][CMD_W-1:0] s_cmd; // Command selectors
  logic [1:0][NUM_W-1:0] s_num; // Message numbers
  logic [1:0] busy; // Busy flags
  logic [1:0][31:0] s_msk; // Buffer mask
  logic [1:0][31:0] s_arb; // Buffer arbitration
  logic [1:0][15:0] s_ctl; // Buffer control
  logic [1:0][31:0] s_da; // Buffer data bytes 0-3
  logic [1:0][31:0] s_db; // Buffer data bytes 4-7
  logic [1:0] s_wr; // Write strobe per set
  logic [1:0][ADDR_W-1:0] s_off; // Offset inside each set
  logic [1:0] s_hit; // Address falls in a set
  logic [1:0][CMD_W-1:0] s_ld; // Read-load selects per set
  logic [1:0] s_done; // End of transfer per set
  // ------------------------------------------------------------
  // Engine wires
  // ------------------------------------------------------------
  logic fire; // Transfer lands this cycle
  logic [CMD_W-1:0] f_cmd; // Selector of served set
  logic [NUM_W-1:0] f_num; // Number of served set
  logic [IDX_W-1:0] f_idx; // Folded object index
  cmit_obj_t f_obj; // Addressed object before update
  cmit_obj_t f_buf; // Buffer of served set
  cmit_obj_t w_obj; // Object after a write transfer
  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  // Only even addresses inside a set's window hit
  always_comb
  begin
    s_off[0] = i_addr - SET1_BASE;
    s_off[1] = i_addr - SET2_BASE;
    s_hit[0] = (i_addr >= SET1_BASE) && (s_off[0] <= OFF_DB2);
    s_hit[1] = (i_addr >= SET2_BASE) && (s_off[1] <= OFF_DB2);
    s_hit = s_hit & {2{~i_addr[0]}};
    s_wr = s_hit & {2{i_wr}};
  end
  // ------------------------------------------------------------
  // Interface register sets
  // ------------------------------------------------------------
  // Two identical sets; software may use one per direction
  for (genvar g = 0; g < 2; g++)
  begin : g_set
    cmit_ifset u_set (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_wr(s_wr[g]),
      .i_off(s_off[g]),
      .i_wdata(i_wdata),
      .i_done(s_done[g]),
      .i_ld(s_ld[g]),
      .i_msk(f_obj.msk),
      .i_arb(f_obj.arb),
      .i_ctl(f_obj.ctl),
      .i_da(f_obj.da),
      .i_db(f_obj.db),
      .o_cmd(s_cmd[g]),
      .o_num(s_num[g]),
      .o_busy(busy[g]),
      .o_msk(s_msk[g]),
      .o_arb(s_arb[g]),
      .o_ctl(s_ctl[g]),
      .o_da(s_da[g]),
      .o_db(s_db[g])
    );
  end
  // ------------------------------------------------------------
  // Object addressing
  // ------------------------------------------------------------
  cmit_fold u_fold (
    .i_num(f_num),
    .o_idx(f_idx)
  );
  // Select the served set's command and buffer
  always_comb
  begin
    fire = (q.st == ENG_RUN) && (q.cnt == FIRE_CNT);
    f_cmd = s_cmd[q.who];
    f_num = s_num[q.who];
    f_obj = q.ram[f_idx];
    // Same layout on both sides, so whole fields are moved
    f_buf = '{msk: s_msk[q.who], arb: s_arb[q.who],
              ctl: s_ctl[q.who], da: s_da[q.who], db: s_db[q.who]};
  end
  // ------------------------------------------------------------
  // Write transfer: buffer to object
  // ------------------------------------------------------------
  // Bit 3 plays no part in this direction
  always_comb
  begin
    w_obj = f_obj;
    if (f_cmd[CM_MASK]) w_obj.msk = f_buf.msk;
    if (f_cmd[CM_ARB]) w_obj.arb = f_buf.arb;
    if (f_cmd[CM_CTL]) w_obj.ctl = f_buf.ctl;
    // Applied after the control copy so the selector wins
    if (f_cmd[CM_REQ]) w_obj.ctl[CTL_TXRQ] = 1'b1;
    if (f_cmd[CM_DA]) w_obj.da = f_buf.da;
    if (f_cmd[CM_DB]) w_obj.db = f_buf.db;
  end
  // ------------------------------------------------------------
  // Read transfer: load selects and end pulses
  // ------------------------------------------------------------
  // The buffer loads f_obj, the object as it stood before clearing
  always_comb
  begin
    for (int k = 0; k < 2; k++)
    begin
      s_done[k] = fire && (q.who == 1'(k));
      s_ld[k] = '0;
      if (s_done[k] && !f_cmd[CM_DIR])
        s_ld[k] = f_cmd & CM_FIELDS;
    end
  end
  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  // Read data, arbitration, and the object update
  always_comb
  begin
    logic [DATA_W-1:0] v;
    logic rs;
    v = '0;
    rs = s_hit[1];
    next_q = q;
    // Read mux; unmapped addresses read zero
    case (s_off[rs])
      OFF_REQ:
      begin
        v = {{(DATA_W-NUM_W){1'b0}}, s_num[rs]};
        v[REQ_BUSY] = busy[rs];
      end
      OFF_CMD: v = {{(DATA_W-CMD_W){1'b0}}, s_cmd[rs]};
      OFF_MSK1: v = s_msk[rs][HALF-1:0];
      OFF_MSK2: v = s_msk[rs][2*HALF-1:HALF];
      OFF_ARB1: v = s_arb[rs][HALF-1:0];
      OFF_ARB2: v = s_arb[rs][2*HALF-1:HALF];
      OFF_CTL: v = s_ctl[rs];
      OFF_DA1: v = s_da[rs][HALF-1:0];
      OFF_DA2: v = s_da[rs][2*HALF-1:HALF];
      OFF_DB1: v = s_db[rs][HALF-1:0];
      OFF_DB2: v = s_db[rs][2*HALF-1:HALF];
      default: v = '0;
    endcase
    // Data stands for the cycle after the strobe only
    next_q.rdata = (i_rd && (|s_hit)) ? v : '0;
    // One transfer owns the RAM from grant to landing
    unique case (q.st)
      ENG_IDLE:
      begin
        if (|busy)
        begin
          next_q.st = ENG_RUN;
          next_q.cnt = '0;
          // Both waiting: serve the one not served last
          next_q.who = (&busy) ? ~q.last : busy[1];
        end
      end
      ENG_RUN:
      begin
        next_q.cnt = q.cnt + CNT_ONE;
        if (fire)
        begin
          next_q.st = ENG_IDLE;
          next_q.last = q.who;
          // Whole group of fields moves in one edge
          if (f_cmd[CM_DIR])
            next_q.ram[f_idx] = w_obj;
          else
          begin
            if (f_cmd[CM_CLRPND])
              next_q.ram[f_idx].ctl[CTL_INTERRUPT_PENDING] = 1'b0;
            if (f_cmd[CM_REQ])
              next_q.ram[f_idx].ctl[CTL_FRESH_DATA_FLAG] = 1'b0;
          end
        end
      end
    endcase
  end
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // RAM content is unspecified at power-up; cleared here
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      q <= '0;
    else
      q <= next_q;
  end
  // Outputs straight from flops
  assign o_rdata = q.rdata;
  assign o_busy = busy;
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  // Request write to an idle set raises busy next cycle
  AST_BUSY_ON:
  assert property (s_wr[0] && s_off[0] == OFF_REQ && !busy[0] |=> busy[0])
    else $error("busy not raised by request write");
  // Busy holds for at least three cycles
  AST_BUSY_HOLD:
  assert property ($rose(busy[1]) |-> busy[1] [*3])
    else $error("busy dropped too early");
  // Busy ends within six cycles
  AST_BUSY_END:
  assert property ($rose(busy[0]) |-> ##[3:6] !busy[0])
    else $error("transfer took too long");
  // Selector request bit sets transmit request on a write
  AST_WR_TXRQ:
  assert property (fire && f_cmd[CM_DIR] && f_cmd[CM_REQ]
    |=> q.ram[$past(f_idx)].ctl[CTL_TXRQ])
    else $error("transmit request not set");
  // Without request bit, transmit request follows control copy
  AST_WR_CTL:
  assert property (fire && f_cmd[CM_DIR] && f_cmd[CM_CTL] && !f_cmd[CM_REQ]
    |=> q.ram[$past(f_idx)].ctl == $past(f_buf.ctl))
    else $error("control bits not copied");
  // Arbitration copy on write
  AST_WR_ARB:
  assert property (fire && f_cmd[CM_DIR] && f_cmd[CM_ARB]
    |=> q.ram[$past(f_idx)].arb == $past(f_buf.arb))
    else $error("arbitration not copied");
  // Unselected data bytes 0-3 survive a write
  AST_WR_KEEP_DA:
  assert property (fire && f_cmd[CM_DIR] && !f_cmd[CM_DA]
    |=> q.ram[$past(f_idx)].da == $past(f_obj.da))
    else $error("data bytes 0-3 disturbed");
  // Read with clear bit drops interrupt pending
  AST_RD_PEND:
  assert property (fire && !f_cmd[CM_DIR] && f_cmd[CM_CLRPND]
    |=> !q.ram[$past(f_idx)].ctl[CTL_INTERRUPT_PENDING])
    else $error("interrupt pending not cleared");
  // Buffer sees control bits from before the clear
  AST_RD_PRE:
  assert property (fire && !f_cmd[CM_DIR] && f_cmd[CM_CTL]
    |=> s_ctl[$past(q.who)] == $past(f_obj.ctl))
    else $error("buffer control not pre-clear value");
  // Unselected mask buffer untouched by a read
  AST_RD_KEEP_MSK:
  assert property (fire && !f_cmd[CM_DIR] && !f_cmd[CM_MASK]
    |=> s_msk[$past(q.who)] == $past(s_msk[q.who]))
    else $error("mask buffer disturbed");
  // Number zero addresses the last object
  AST_FOLD:
  assert property (fire && f_num == '0 |-> f_idx == IDX_W'(NOBJ - 1))
    else $error("number zero not folded");
  // Mask copy on write
  AST_WR_MSK:
  assert property (fire && f_cmd[CM_DIR] && f_cmd[CM_MASK]
    |=> q.ram[$past(f_idx)].msk == $past(f_buf.msk))
    else $error("mask not copied");
  // Unselected mask survives a write
  AST_WR_KEEP_MSK:
  assert property (fire && f_cmd[CM_DIR] && !f_cmd[CM_MASK]
    |=> q.ram[$past(f_idx)].msk == $past(f_obj.msk))
    else $error("object mask disturbed");
  // Neither control copy nor request bit: object control bits kept
  AST_WR_KEEP_CTL:
  assert property (fire && f_cmd[CM_DIR] && !f_cmd[CM_CTL] && !f_cmd[CM_REQ]
    |=> q.ram[$past(f_idx)].ctl == $past(f_obj.ctl))
    else $error("object control disturbed");
  // Data bytes 4-7 copy on write
  AST_WR_DB:
  assert property (fire && f_cmd[CM_DIR] && f_cmd[CM_DB]
    |=> q.ram[$past(f_idx)].db == $past(f_buf.db))
    else $error("data bytes 4-7 not copied");
  // Unselected data bytes 4-7 survive a write
  AST_WR_KEEP_DB:
  assert property (fire && f_cmd[CM_DIR] && !f_cmd[CM_DB]
    |=> q.ram[$past(f_idx)].db == $past(f_obj.db))
    else $error("data bytes 4-7 disturbed");
  // Read with request bit drops the fresh data flag
  AST_RD_FRESH:
  assert property (fire && !f_cmd[CM_DIR] && f_cmd[CM_REQ]
    |=> !q.ram[$past(f_idx)].ctl[CTL_FRESH_DATA_FLAG])
    else $error("fresh data flag not cleared");
  // A read never alters the object's data bytes 0-3
  AST_RD_KEEP_OBJ:
  assert property (fire && !f_cmd[CM_DIR]
    |=> q.ram[$past(f_idx)].da == $past(f_obj.da))
    else $error("read changed object data");
  // Data bytes 4-7 loaded into the buffer on read
  AST_RD_DB:
  assert property (fire && !f_cmd[CM_DIR] && f_cmd[CM_DB]
    |=> s_db[$past(q.who)] == $past(f_obj.db))
    else $error("data bytes 4-7 not loaded");
  // Unselected arbitration buffer untouched by a read
  AST_RD_KEEP_ARB:
  assert property (fire && !f_cmd[CM_DIR] && !f_cmd[CM_ARB]
    |=> s_arb[$past(q.who)] == $past(s_arb[q.who]))
    else $error("arbitration buffer disturbed");
  COV_WRITE: cover property (fire && f_cmd[CM_DIR]);
  COV_READ: cover property (fire && !f_cmd[CM_DIR] && f_cmd[CM_REQ]);
  COV_BOTH: cover property (&busy ##1 fire);
endmodule
`default_nettype wire

// [inc/cmit_pkg.sv]
// Shared constants and types for the message interface transfer block
package cmit_pkg;
  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int HALF = 16;
  localparam int CMD_W = 8;
  localparam int NUM_W = 6;
  localparam int IDX_W = 5;
  localparam int NOBJ = 32;
  // ------------------------------------------------------------
  // Register map: set bases, offsets inside a set
  // ------------------------------------------------------------
  localparam logic [7:0] SET1_BASE = 8'h10;
  localparam logic [7:0] SET2_BASE = 8'h40;
  localparam logic [7:0] OFF_REQ = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h02;
  localparam logic [7:0] OFF_MSK1 = 8'h04;
  localparam logic [7:0] OFF_MSK2 = 8'h06;
  localparam logic [7:0] OFF_ARB1 = 8'h08;
  localparam logic [7:0] OFF_ARB2 = 8'h0A;
  localparam logic [7:0] OFF_CTL = 8'h0C;
  localparam logic [7:0] OFF_DA1 = 8'h0E;
  localparam logic [7:0] OFF_DA2 = 8'h10;
  localparam logic [7:0] OFF_DB1 = 8'h12;
  localparam logic [7:0] OFF_DB2 = 8'h14;
  // ------------------------------------------------------------
  // Command selector bits
  // ------------------------------------------------------------
  localparam int CM_DIR = 7;
  localparam int CM_MASK = 6;
  localparam int CM_ARB = 5;
  localparam int CM_CTL = 4;
  localparam int CM_CLRPND = 3;
  localparam int CM_REQ = 2;
  localparam int CM_DA = 1;
  localparam int CM_DB = 0;
  localparam logic [7:0] CM_FIELDS = 8'h73;
  // ------------------------------------------------------------
  // Field positions and writable-bit masks
  // ------------------------------------------------------------
  localparam int REQ_BUSY = 15;
  localparam int CTL_FRESH_DATA_FLAG = 15;
  localparam int CTL_INTERRUPT_PENDING = 13;
  localparam int CTL_TXRQ = 8;
  localparam logic [15:0] MSK2_RW = 16'hDFFF;
  localparam logic [15:0] CTL_RW = 16'hFF8F;
  localparam logic [5:0] NUM_STEP = 6'h01;
  // ------------------------------------------------------------
  // Transfer timing in link clock cycles
  // ------------------------------------------------------------
  localparam int XFER_MIN_CYC = 3;
  localparam logic [1:0] FIRE_CNT = 2'(XFER_MIN_CYC - 2);
  localparam logic [1:0] CNT_ONE = 2'h1;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  // Buffer and object share one layout so fields move one to one
  typedef struct packed {
    logic [31:0] msk;
    logic [31:0] arb;
    logic [15:0] ctl;
    logic [31:0] da;
    logic [31:0] db;
  } cmit_obj_t;
  typedef struct packed {
    logic [CMD_W-1:0] cmd;
    logic [NUM_W-1:0] num;
    logic busy;
    cmit_obj_t b;
  } cmit_set_t;
  typedef enum logic {ENG_IDLE, ENG_RUN} cmit_eng_t;
endpackage

// [design/cmit_fold.sv]
// Message number to object index folding
`timescale 1ns/1ns
`default_nettype none
module cmit_fold (
  input wire logic [cmit_pkg::NUM_W-1:0] i_num,
  output logic [cmit_pkg::IDX_W-1:0] o_idx
);
  import cmit_pkg::*;
  // ------------------------------------------------------------
  // Fold
  // ------------------------------------------------------------
  // Index is number minus one modulo 32: 0 lands on the last object
  // and the upper half wraps onto 0..31, so no number is refused
  logic [NUM_W-1:0] dec;
  assign dec = i_num - NUM_STEP;
  assign o_idx = dec[IDX_W-1:0];
endmodule
`default_nettype wire

// [design/cmit_ifset.sv]
// One interface register set: command registers and message buffer
`timescale 1ns/1ns
`default_nettype none
module cmit_ifset (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic [cmit_pkg::ADDR_W-1:0] i_off,
  input wire logic [cmit_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_done,
  input wire logic [cmit_pkg::CMD_W-1:0] i_ld,
  input wire logic [31:0] i_msk,
  input wire logic [31:0] i_arb,
  input wire logic [15:0] i_ctl,
  input wire logic [31:0] i_da,
  input wire logic [31:0] i_db,
  output logic [cmit_pkg::CMD_W-1:0] o_cmd,
  output logic [cmit_pkg::NUM_W-1:0] o_num,
  output logic o_busy,
  output logic [31:0] o_msk,
  output logic [31:0] o_arb,
  output logic [15:0] o_ctl,
  output logic [31:0] o_da,
  output logic [31:0] o_db
);
  import cmit_pkg::*;
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  cmit_set_t q; // Registered set
  cmit_set_t next_q; // Next value
  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  // Software writes and transfer loads
  always_comb
  begin
    next_q = q;
    // Software writes are ignored while busy so a transfer sees stable data
    if (i_wr && !q.busy)
    begin
      case (i_off)
        OFF_REQ:
        begin
          next_q.num = i_wdata[NUM_W-1:0];
          next_q.busy = 1'b1;
        end
        OFF_CMD: next_q.cmd = i_wdata[CMD_W-1:0];
        OFF_MSK1: next_q.b.msk[HALF-1:0] = i_wdata;
        OFF_MSK2: next_q.b.msk[2*HALF-1:HALF] = i_wdata & MSK2_RW;
        OFF_ARB1: next_q.b.arb[HALF-1:0] = i_wdata;
        OFF_ARB2: next_q.b.arb[2*HALF-1:HALF] = i_wdata;
        OFF_CTL: next_q.b.ctl = i_wdata & CTL_RW;
        OFF_DA1: next_q.b.da[HALF-1:0] = i_wdata;
        OFF_DA2: next_q.b.da[2*HALF-1:HALF] = i_wdata;
        OFF_DB1: next_q.b.db[HALF-1:0] = i_wdata;
        OFF_DB2: next_q.b.db[2*HALF-1:HALF] = i_wdata;
        default: ; // Holes in the set store nothing
      endcase
    end
    // End of transfer: busy drops, read data lands in selected fields
    if (i_done)
    begin
      next_q.busy = 1'b0;
      if (i_ld[CM_MASK]) next_q.b.msk = i_msk;
      if (i_ld[CM_ARB]) next_q.b.arb = i_arb;
      if (i_ld[CM_CTL]) next_q.b.ctl = i_ctl;
      if (i_ld[CM_DA]) next_q.b.da = i_da;
      if (i_ld[CM_DB]) next_q.b.db = i_db;
    end
  end
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Buffer reset value is unspecified; zero is used
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      q <= '0;
    else
      q <= next_q;
  end
  // Outputs straight from the flops
  assign o_cmd = q.cmd;
  assign o_num = q.num;
  assign o_busy = q.busy;
  assign o_msk = q.b.msk;
  assign o_arb = q.b.arb;
  assign o_ctl = q.b.ctl;
  assign o_da = q.b.da;
  assign o_db = q.b.db;
endmodule
`default_nettype wire

// [tb/cmit_cpu_model.sv]
// Register bus master model: the software side of the transfer block
`timescale 1ns/1ns
`default_nettype none
module cmit_cpu_model (
  input wire logic i_ref_clk,
  input wire logic [cmit_pkg::DATA_W-1:0] i_rdata,
  output logic [cmit_pkg::ADDR_W-1:0] o_addr,
  output logic [cmit_pkg::DATA_W-1:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  import cmit_pkg::*;
  // ------------------------------------------------------------
  // Bus idle state
  // ------------------------------------------------------------
  // Idle at time zero so no strobe is ever seen as unknown
  initial
  begin
    o_addr = 8'h00;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  // One-cycle write; the spare cycle after it keeps a strobe from being
  // assigned twice in one step when calls follow each other.
  // Callers fill selector and buffer before the request, never while busy
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_ref_clk);
    o_wr <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  // Read: data stands only in the cycle after the strobe, so take it there
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_ref_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
    @(posedge i_ref_clk);
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the message interface transfer block
`timescale 1ns/1ns
`default_nettype none
// Compare one value, count it, report a mismatch at once
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  import cmit_pkg::*;
  // ------------------------------------------------------------
  // Clock, reset, bus wires
  // ------------------------------------------------------------
  logic i_ref_clk;
  logic i_rst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic wr;
  logic rd;
  logic [1:0] busy;
  int error_cnt = 0;
  int checks = 0;
  // Object pattern: reserved bits kept 0 so readback needs no masking
  localparam cmit_obj_t PA = '{32'h9ABC_1234, 32'hC123_4567, 16'hA08F, 32'h3322_1100,
    32'h7766_5544};
  localparam cmit_obj_t PB = '{32'h1F0F_F0F0, 32'h1EEE_EEEE, 16'h0003, 32'hDDCC_BBAA,
    32'h0000_0000};
  initial
  begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  cmit_cpu_model cpu (
    .i_ref_clk(i_ref_clk),
    .i_rdata(rdata),
    .o_addr(addr),
    .o_wdata(wdata),
    .o_wr(wr),
    .o_rd(rd)
  );
  cmit_top dut (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_addr(addr),
    .i_wdata(wdata),
    .i_wr(wr),
    .i_rd(rd),
    .o_rdata(rdata),
    .o_busy(busy)
  );
  // ------------------------------------------------------------
  // Helper tasks
  // ------------------------------------------------------------
  // Verdict and end of run, shared with the watchdog
  task automatic finish_test();
    if (error_cnt == 0 && checks > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Fill a set's buffer, low word of each field at the lower offset
  task automatic put(input logic [7:0] b, input cmit_obj_t o);
    logic [15:0] w [9];
    w = '{o.msk[15:0], o.msk[31:16], o.arb[15:0], o.arb[31:16], o.ctl, o.da[15:0],
      o.da[31:16], o.db[15:0], o.db[31:16]};
    for (int i = 0; i < 9; i++)
    begin
      cpu.wr(b + OFF_MSK1 + 8'(2 * i), w[i]);
    end
  endtask
  // Read a whole buffer back and compare word by word
  task automatic chk(input logic [7:0] b, input cmit_obj_t o);
    logic [15:0] w [9];
    logic [15:0] d;
    w = '{o.msk[15:0], o.msk[31:16], o.arb[15:0], o.arb[31:16], o.ctl, o.da[15:0],
      o.da[31:16], o.db[15:0], o.db[31:16]};
    for (int i = 0; i < 9; i++)
    begin
      cpu.rd(b + OFF_MSK1 + 8'(2 * i), d);
      `CHK(d, w[i])
    end
  endtask
  // Start a transfer and count edges until the set's busy falls;
  // returning only when idle keeps the set untouched while busy
  task automatic go(input logic [7:0] b, input logic [5:0] num, input int k, output int n);
    cpu.wr(b + OFF_REQ, {10'h000, num});
    #1;
    n = 1;
    while (busy[k] === 1'b1 && n < 12)
    begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    @(posedge i_ref_clk);
  endtask
  // ------------------------------------------------------------
  // Watchdog: the whole sequence needs well under 1000 cycles
  // ------------------------------------------------------------
  initial
  begin
    repeat (5000) @(posedge i_ref_clk);
    error_cnt++;
    finish_test();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [15:0] d;
    int n;
    cmit_obj_t e;
    i_rst = 1'b1;
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    `CHK(busy, 2'b00)
    @(posedge i_ref_clk);
    cpu.rd(SET1_BASE + OFF_CMD, d);
    `CHK(d, 16'h0000)
    cpu.rd(8'h30, d);
    `CHK(d, 16'h0000)
    // Full write with ignored clear bit and transmit set; number folds to 1
    put(SET1_BASE, PA);
    cpu.wr(SET1_BASE + OFF_CMD, 16'h00FF);
    go(SET1_BASE, 6'h21, 0, n);
    `CHK(n, 3)
    cpu.rd(SET1_BASE + OFF_REQ, d);
    `CHK(d, 16'h0021)
    // Read all fields through the other set: pending kept, request forced
    e = PA;
    e.ctl = 16'hA18F;
    cpu.wr(SET2_BASE + OFF_CMD, 16'h0073);
    go(SET2_BASE, 6'h01, 1, n);
    chk(SET2_BASE, e);
    // Clearing read: buffer shows values from before the clear
    cpu.wr(SET1_BASE + OFF_CMD, 16'h001C);
    go(SET1_BASE, 6'h01, 0, n);
    chk(SET1_BASE, e);
    cpu.wr(SET1_BASE + OFF_CMD, 16'h0010);
    go(SET1_BASE, 6'h01, 0, n);
    e.ctl = 16'h018F;
    chk(SET1_BASE, e);
    // Write of data bytes 0-3 only: all other object fields preserved
    put(SET1_BASE, PB);
    cpu.wr(SET1_BASE + OFF_CMD, 16'h0082);
    go(SET1_BASE, 6'h01, 0, n);
    e.da = PB.da;
    go(SET2_BASE, 6'h01, 1, n);
    chk(SET2_BASE, e);
    // Control-only write, no request bit: buffer control copied, bytes kept
    cpu.wr(SET1_BASE + OFF_CMD, 16'h0090);
    go(SET1_BASE, 6'h01, 0, n);
    e.ctl = PB.ctl;
    go(SET2_BASE, 6'h01, 1, n);
    chk(SET2_BASE, e);
    // Read of bytes 4-7 only from number 0, the last object, still clear
    cpu.wr(SET2_BASE + OFF_CMD, 16'h0001);
    go(SET2_BASE, 6'h00, 1, n);
    e.db = 32'h0000_0000;
    chk(SET2_BASE, e);
    // Both sets requested back to back: second waits its turn
    cpu.wr(SET1_BASE + OFF_REQ, 16'h0001);
    go(SET2_BASE, 6'h02, 1, n);
    `CHK(1'(n >= 3 && n <= 6), 1'b1)
    `CHK(busy, 2'b00)
    // Request register shows number and busy while a transfer runs
    cpu.wr(SET1_BASE + OFF_REQ, 16'h0021);
    cpu.rd(SET1_BASE + OFF_REQ, d);
    `CHK(d, 16'h8021)
    finish_test();
  end
endmodule
`default_nettype wire
